/* design/nmi_soft_pkg.sv */
package nmi_soft_pkg;
  localparam logic [31:0] CAUSE_PIN = 32'h0000_0000;
  localparam logic [31:0] CAUSE_STORE = 32'hf000_0000;
  localparam logic [31:0] CAUSE_LOAD = 32'hf000_0001;
  localparam logic [31:0] CAUSE_ECC2 = 32'hf000_1000;
  localparam logic [31:0] CAUSE_DREG = 32'hf000_1001;
  localparam logic [31:0] CAUSE_NDREG = 32'hf000_1002;
  localparam int NSRC = 6;
  localparam int SRC_PIN = 0;
  localparam int SRC_STORE = 1;
  localparam int SRC_LOAD = 2;
  localparam int SRC_ECC2 = 3;
  localparam int SRC_DREG = 4;
  localparam int SRC_NDREG = 5;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_MASK = 4'h8;
  localparam logic [3:0] OFF_VEC = 4'hc;
  localparam int ST_NMI_PULSE = 0;
  localparam int ST_SOFT_SET = 1;
  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [2:0] PIN_HOLD = 3'h3;
  localparam logic [2:0] PIN_GAP = 3'h3;
  typedef enum logic [1:0] {
    SRV_IDLE = 2'b01,
    SRV_TAKE = 2'b10
  } srv_state_t;
  function automatic logic [31:0] cause_of(input logic [2:0] idx);
    case (idx)
      3'h0: cause_of = CAUSE_PIN;
      3'h1: cause_of = CAUSE_STORE;
      3'h2: cause_of = CAUSE_LOAD;
      3'h3: cause_of = CAUSE_ECC2;
      3'h4: cause_of = CAUSE_DREG;
      default: cause_of = CAUSE_NDREG;
    endcase
  endfunction
endpackage

/* design/nmi_soft_if.sv */
`timescale 1ns/1ps
interface nmi_soft_if;
  logic [31:1] nmi_vec;
  logic nmi_req;
  logic soft_irq;
  modport core (input nmi_vec, input nmi_req, input soft_irq);
  modport soc (output nmi_vec, output nmi_req, output soft_irq);
endinterface

/* design/nmi_soft_core.sv */
`timescale 1ns/1ps
module nmi_soft_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link to system logic
  nmi_soft_if.core link,
  // Core internal error sources, one-cycle pulses
  input wire logic store_err_i,
  input wire logic load_err_i,
  input wire logic ecc2_err_i,
  input wire logic dreg_err_i,
  input wire logic ndreg_err_i,
  // Machine software enable and retire handshake
  input wire logic msie_i,
  input wire logic trap_ack_i,
  // Trap outputs
  output logic nmi_take_o,
  output logic [31:0] fetch_pc_o,
  output logic [31:0] cause_o,
  output logic msip_o,
  output logic soft_take_o
);
  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [2:0] nmi_sync_reg, nmi_sync_next;
  logic [2:0] soft_sync_reg, soft_sync_next;
  logic nmi_lvl_reg, nmi_lvl_next;
  logic soft_lvl_reg, soft_lvl_next;
  logic nmi_edge;

  always_comb begin
    nmi_sync_next = {nmi_sync_reg[1:0], link.nmi_req};
    soft_sync_next = {soft_sync_reg[1:0], link.soft_irq};
    nmi_lvl_next = nmi_lvl_reg;
    soft_lvl_next = soft_lvl_reg;
    if (nmi_sync_reg[1] == nmi_sync_reg[2]) begin
      nmi_lvl_next = nmi_sync_reg[2];
    end
    if (soft_sync_reg[1] == soft_sync_reg[2]) begin
      soft_lvl_next = soft_sync_reg[2];
    end
    nmi_edge = nmi_lvl_next & ~nmi_lvl_reg;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      nmi_sync_reg <= 3'h0;
      soft_sync_reg <= 3'h0;
      nmi_lvl_reg <= 1'b0;
      soft_lvl_reg <= 1'b0;
    end else begin
      nmi_sync_reg <= nmi_sync_next;
      soft_sync_reg <= soft_sync_next;
      nmi_lvl_reg <= nmi_lvl_next;
      soft_lvl_reg <= soft_lvl_next;
    end
  end

  // ----------------------------------------
  // NMI merge and service
  // ----------------------------------------
  logic [nmi_soft_pkg::NSRC-1:0] pend_reg, pend_next, src;
  logic [31:0] pc_reg, pc_next;
  logic [31:0] cause_reg, cause_next;
  logic take_reg, take_next;
  logic [2:0] pick;
  logic found;

  always_comb begin
    src = '0;
    src[nmi_soft_pkg::SRC_PIN] = nmi_edge;
    src[nmi_soft_pkg::SRC_STORE] = store_err_i;
    src[nmi_soft_pkg::SRC_LOAD] = load_err_i;
    src[nmi_soft_pkg::SRC_ECC2] = ecc2_err_i;
    src[nmi_soft_pkg::SRC_DREG] = dreg_err_i;
    src[nmi_soft_pkg::SRC_NDREG] = ndreg_err_i;
    pick = 3'h0;
    found = 1'b0;
    for (int i = nmi_soft_pkg::NSRC - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        pick = 3'(i);
        found = 1'b1;
      end
    end
    pend_next = pend_reg | src;
    pc_next = pc_reg;
    cause_next = cause_reg;
    take_next = 1'b0;
    // Mode selection of ordinary interrupts is not consulted here.
    if (found && !take_reg) begin
      pend_next[pick] = src[pick];
      pc_next = {link.nmi_vec, 1'b0};
      cause_next = nmi_soft_pkg::cause_of(pick);
      take_next = 1'b1;
    end else if (take_reg && !trap_ack_i) begin
      take_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_reg <= '0;
      pc_reg <= nmi_soft_pkg::VEC_RESET;
      cause_reg <= nmi_soft_pkg::CAUSE_PIN;
      take_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      pc_reg <= pc_next;
      cause_reg <= cause_next;
      take_reg <= take_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign nmi_take_o = take_reg;
  assign fetch_pc_o = pc_reg;
  assign cause_o = cause_reg;
  assign msip_o = soft_lvl_reg;
  assign soft_take_o = soft_lvl_reg & msie_i;
endmodule

/* design/nmi_soft_soc.sv */
`timescale 1ns/1ps
module nmi_soft_soc (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq_o,
  // Link to core
  nmi_soft_if.soc link
);
  // ----------------------------------------
  // Registers and NMI pulse shaper
  // ----------------------------------------
  logic soft_reg, soft_next;
  logic [31:0] vec_reg, vec_next;
  logic [1:0] stat_reg, stat_next;
  logic [1:0] mask_reg, mask_next;
  logic [31:0] rd_reg, rd_next;
  logic [2:0] cnt_reg, cnt_next;
  logic pin_reg, pin_next;
  logic fire_req_reg, fire_req_next;
  logic ack_reg, ack_next;
  logic wr_ctrl;

  always_comb begin
    soft_next = soft_reg;
    vec_next = vec_reg;
    stat_next = stat_reg;
    mask_next = mask_reg;
    fire_req_next = fire_req_reg;
    pin_next = pin_reg;
    cnt_next = cnt_reg;
    rd_next = 32'h0;
    ack_next = (avs_read | avs_write) & ~ack_reg;
    wr_ctrl = avs_write & ~ack_reg & (avs_address == nmi_soft_pkg::OFF_CTRL);
    if (avs_write && !ack_reg) begin
      unique case (avs_address)
        nmi_soft_pkg::OFF_STATUS: stat_next = stat_reg & ~avs_writedata[1:0];
        nmi_soft_pkg::OFF_MASK: mask_next = avs_writedata[1:0];
        nmi_soft_pkg::OFF_VEC: vec_next = {avs_writedata[31:1], 1'b0};
        default: ;
      endcase
    end
    if (wr_ctrl) begin
      soft_next = avs_writedata[0];
      if (avs_writedata[1]) begin
        fire_req_next = 1'b1;
      end
    end
    // The pin stays low unless fired; unused it stays zero.
    if (cnt_reg != 3'h0) begin
      cnt_next = cnt_reg - 3'h1;
    end else if (pin_reg) begin
      pin_next = 1'b0;
      cnt_next = nmi_soft_pkg::PIN_GAP;
    end else if (fire_req_reg) begin
      pin_next = 1'b1;
      cnt_next = nmi_soft_pkg::PIN_HOLD;
      fire_req_next = 1'b0;
      stat_next[nmi_soft_pkg::ST_NMI_PULSE] = 1'b1;
    end
    if (wr_ctrl && avs_writedata[0] && !soft_reg) begin
      stat_next[nmi_soft_pkg::ST_SOFT_SET] = 1'b1;
    end
    if (avs_read && !ack_reg) begin
      unique case (avs_address)
        nmi_soft_pkg::OFF_CTRL: rd_next = {30'h0, fire_req_reg | pin_reg, soft_reg};
        nmi_soft_pkg::OFF_STATUS: rd_next = {30'h0, stat_reg};
        nmi_soft_pkg::OFF_MASK: rd_next = {30'h0, mask_reg};
        nmi_soft_pkg::OFF_VEC: rd_next = vec_reg;
        default: rd_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_reg <= 1'b0;
      vec_reg <= nmi_soft_pkg::VEC_RESET;
      stat_reg <= 2'h0;
      mask_reg <= 2'h0;
      rd_reg <= 32'h0;
      cnt_reg <= 3'h0;
      pin_reg <= 1'b0;
      fire_req_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      soft_reg <= soft_next;
      vec_reg <= vec_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      pin_reg <= pin_next;
      fire_req_reg <= fire_req_next;
      ack_reg <= ack_next;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata = rd_reg;
  assign irq_o = |(stat_reg & mask_reg);
  assign link.nmi_vec = vec_reg[31:1];
  assign link.nmi_req = pin_reg;
  assign link.soft_irq = soft_reg;
endmodule

/* tb/nmi_soft_props.sv */
`timescale 1ns/1ps
module nmi_soft_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched signals
  input wire logic [31:1] nmi_vec,
  input wire logic nmi_req,
  input wire logic soft_irq,
  input wire logic msie_i,
  input wire logic trap_ack_i,
  input wire logic nmi_take_o,
  input wire logic [31:0] fetch_pc_o,
  input wire logic [31:0] cause_o,
  input wire logic msip_o,
  input wire logic soft_take_o
);
  // ----
  // Link checks.
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_req_high_two: assert property ($rose(nmi_req) |=> nmi_req)
    else $error("nmi request pulse too short");
  a_req_low_two: assert property ($fell(nmi_req) |=> !nmi_req)
    else $error("nmi request gap too short");
  a_pin_take: assert property ($rose(nmi_req) |-> ##[2:8] nmi_take_o)
    else $error("nmi pin edge not taken");
  a_take_pc: assert property ($rose(nmi_take_o) |-> fetch_pc_o == {nmi_vec, 1'b0})
    else $error("fetch address differs from vector");
  a_take_holds: assert property (nmi_take_o && !trap_ack_i |=> nmi_take_o)
    else $error("nmi take dropped early");
  a_cause_legal: assert property (nmi_take_o |-> cause_o == 32'h0 || cause_o[31:28] == 4'hf)
    else $error("illegal cause code");
  a_msip_sync: assert property ($rose(soft_irq) |-> !msip_o ##1 !msip_o)
    else $error("software pin not synchronised");
  a_msip_rise: assert property ($rose(soft_irq) |-> ##[2:5] msip_o)
    else $error("pending bit did not follow pin high");
  a_msip_fall: assert property ($fell(soft_irq) |-> ##[2:5] !msip_o)
    else $error("pending bit did not follow pin low");
  a_soft_take: assert property (soft_take_o == (msip_o && msie_i))
    else $error("software take wrong");
  c_pin: cover property ($rose(nmi_take_o) && cause_o == 32'h0);
  c_load: cover property ($rose(nmi_take_o) && cause_o == 32'hf000_0001);
  c_soft: cover property (soft_take_o);
endmodule

/* tb/nmi_and_soft_interrupt_inputs_test.sv */
`timescale 1ns/1ps
module nmi_and_soft_interrupt_inputs_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, fetch_pc_o, cause_o, rd;
  logic avs_waitrequest, irq_o, nmi_take_o, msip_o, soft_take_o;
  logic [4:0] err = 5'h0;
  logic msie_i = 1'b0;
  logic trap_ack_i = 1'b0;
  logic [31:0] cz [5] = '{32'hf000_0000, 32'hf000_0001, 32'hf000_1000, 32'hf000_1001, 32'hf000_1002};
  int miscompares = 0;
  int total_checks = 0;
  // ----
  // Structure.
  // ----
  nmi_soft_if i_nmi_soft_if ();
  nmi_soft_core i_nmi_soft_core (.clk_i(clk_i), .rst_i(rst_i), .link(i_nmi_soft_if.core),
    .store_err_i(err[0]), .load_err_i(err[1]), .ecc2_err_i(err[2]), .dreg_err_i(err[3]),
    .ndreg_err_i(err[4]), .msie_i(msie_i), .trap_ack_i(trap_ack_i), .nmi_take_o(nmi_take_o),
    .fetch_pc_o(fetch_pc_o), .cause_o(cause_o), .msip_o(msip_o), .soft_take_o(soft_take_o));
  nmi_soft_soc i_nmi_soft_soc (.clk_i(clk_i), .rst_i(rst_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_o(irq_o),
    .link(i_nmi_soft_if.soc));
  nmi_soft_props i_nmi_soft_props (.clk_i(clk_i), .rst_i(rst_i), .nmi_vec(i_nmi_soft_if.nmi_vec),
    .nmi_req(i_nmi_soft_if.nmi_req), .soft_irq(i_nmi_soft_if.soft_irq), .msie_i(msie_i),
    .trap_ack_i(trap_ack_i), .nmi_take_o(nmi_take_o), .fetch_pc_o(fetch_pc_o), .cause_o(cause_o),
    .msip_o(msip_o), .soft_take_o(soft_take_o));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic take(input logic [31:0] c);
    int n;
    n = 0;
    while (nmi_take_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk("take", nmi_take_o, 32'h1);
    chk("cause", cause_o, c);
    chk("pc", fetch_pc_o, 32'h8000_1234);
    trap_ack_i <= 1'b1;
    @(posedge clk_i);
    trap_ack_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 4'(i * 4), 32'h0);
      chk("reset", rd, 32'h0);
    end
    bus(1'b1, 4'h2, 32'hffff_ffff);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, 4'hc, 32'h8000_1235);
    bus(1'b0, 4'hc, 32'h0);
    chk("vec", rd, 32'h8000_1234);
  endtask
  task automatic t_pin();
    bus(1'b1, 4'h8, 32'h1);
    bus(1'b1, 4'h0, 32'h2);
    take(32'h0);
    chk("irq", irq_o, 32'h1);
    bus(1'b1, 4'h4, 32'h1);
    chk("irq", irq_o, 32'h0);
    bus(1'b1, 4'h8, 32'h0);
    bus(1'b1, 4'h0, 32'h2);
    take(32'h0);
    chk("irq", irq_o, 32'h0);
    bus(1'b0, 4'h4, 32'h0);
    chk("status", rd, 32'h1);
  endtask
  task automatic t_errs();
    for (int i = 0; i < 5; i++) begin
      err <= 5'(1 << i);
      @(posedge clk_i);
      err <= 5'h0;
      take(cz[i]);
    end
    err <= 5'h3;
    @(posedge clk_i);
    err <= 5'h0;
    take(cz[0]);
    take(cz[1]);
  endtask
  task automatic t_soft();
    bus(1'b1, 4'h8, 32'h2);
    bus(1'b1, 4'h0, 32'h1);
    repeat (6) @(posedge clk_i);
    chk("msip", msip_o, 32'h1);
    chk("soft_take", soft_take_o, 32'h0);
    chk("irq", irq_o, 32'h1);
    msie_i <= 1'b1;
    @(posedge clk_i);
    chk("soft_take", soft_take_o, 32'h1);
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h4, 32'h2);
    repeat (6) @(posedge clk_i);
    chk("msip", msip_o, 32'h0);
    chk("irq", irq_o, 32'h0);
  endtask
  task automatic close_out();
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_pin();
    t_errs();
    t_soft();
    close_out();
  end
endmodule
